// ===== inc/cgcr_consts.svh
// Named constants of the clock generator configuration register bank.
`ifndef CGCR_CONSTS_SVH
`define CGCR_CONSTS_SVH
`define CGCR_DEV_WR 8'hd2
`define CGCR_DEV_RD 8'hd3
`define CGCR_IDX_IDENT 8'h07
`define CGCR_IDX_MAPA 8'h08
`define CGCR_IDX_DISP 8'h09
`define CGCR_IDX_CNT 8'h0a
`define CGCR_IDX_P1H 8'h0b
`define CGCR_IDX_P1L 8'h0c
`define CGCR_IDX_S1L 8'h0d
`define CGCR_IDX_S1H 8'h0e
`define CGCR_IDX_MAPB 8'h0f
`define CGCR_IDX_SATA 8'h10
`define CGCR_IDX_P2H 8'h11
`define CGCR_IDX_P2L 8'h12
`define CGCR_IDX_S2L 8'h13
`define CGCR_IDX_S2H 8'h14
`define CGCR_IDENT_CODE 8'ha5
`define CGCR_RST_MAPA 8'h3c
`define CGCR_RST_MAPB 8'h00
`define CGCR_RST_DISP 8'h76
`define CGCR_RST_CNT 8'h15
`define CGCR_RST_SATA 8'h9d
`define CGCR_RST_SPREAD 8'h00
`define CGCR_ROM_P1H 8'h00
`define CGCR_ROM_P1L 8'h00
`define CGCR_ROM_P2H 8'h00
`define CGCR_ROM_P2L 8'h00
`define CGCR_WMASK_DISP 8'hf7
`define CGCR_WMASK_SSH1 8'h7f
`define CGCR_WMASK_P2L 8'h7f
`define CGCR_CNT_MASK 8'h1f
`define CGCR_LAST_BIT 3'h7
`define CGCR_PH_INDEX 2'h0
`define CGCR_PH_COUNT 2'h1
`define CGCR_PH_DATA 2'h2
`define CGCR_DISP_SS_MSB 7
`define CGCR_DISP_SS_LSB 4
`define CGCR_DISP_STRAP 3
`define CGCR_DISP_REF0 2
`define CGCR_DISP_SSEN 1
`define CGCR_DISP_PROG 0
`define CGCR_SATA_SEL 7
`define CGCR_SATA_SRC 6
`define CGCR_SATA_PCIE 5
`define CGCR_SATA_SSEN 4
`define CGCR_SATA_SS_MSB 3
`define CGCR_SATA_SS_LSB 2
`define CGCR_SATA_PCI 1
`define CGCR_SS_HI_MSB 6
`define CGCR_N8_BIT 7
`define CGCR_N9_BIT 6
`define CGCR_M_MSB 5
`define CGCR_MAP_HI 7
`define CGCR_MAP_MID 6
`define CGCR_MAP_B5 5
`define CGCR_MAP_LO1 1
`define CGCR_MAP_LO0 0
`define CGCR_LINK_EN_RST 9'h1ff
`endif

// ===== inc/cgcr_pkg.sv
// Types of the clock generator configuration register bank.
`default_nettype none
package cgcr_pkg;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_ADDR = 3'b001,
      S_RECV = 3'b010,
      S_ACK = 3'b011,
      S_SEND = 3'b100,
      S_MACK = 3'b101
   } cgcr_st_t;
   typedef struct packed {
      cgcr_st_t st;
      logic scl_q, sda_q, byte_done, is_read, nack;
      logic sda_oe_n, sda_out, straps_done;
      logic [7:0] sh;
      logic [2:0] bitcnt;
      logic [1:0] phase;
      logic [7:0] ptr;
      logic [7:0] map_a, disp, cnt, p1h, p1l, s1l, s1h;
      logic [7:0] map_b, sata, p2h, p2l, s2l, s2h;
      logic wr_p1h, wr_p1l, wr_p2h, wr_p2l;
   } cgcr_top_t;
   typedef struct packed {
      logic [9:0] n;
      logic [5:0] m;
      logic hi_seen, lo_seen;
   } cgcr_pll_t;
   typedef struct packed {
      logic [8:0] en;
   } cgcr_gate_t;
endpackage : cgcr_pkg
`default_nettype wire

// ===== hw/cgcr_pll_apply.sv
// Divider staging for one PLL: both bytes must arrive before the PLL sees them.
`timescale 1ns/1ps
`default_nettype none
`include "cgcr_consts.svh"
module cgcr_pll_apply #(
   parameter logic [7:0] RST_HI = 8'h00,
   parameter logic [7:0] RST_LO = 8'h00
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] div_hi,
   input wire logic [7:0] div_lo,
   input wire logic wr_hi,
   input wire logic wr_lo,
   input wire logic prog_en,
   output logic [9:0] fb_div,
   output logic [5:0] in_div
);
   cgcr_pkg::cgcr_pll_t r;
   cgcr_pkg::cgcr_pll_t next_r;

   always_comb begin
      next_r = r;
      if (wr_hi) begin
         next_r.hi_seen = 1'b1;
      end
      if (wr_lo) begin
         next_r.lo_seen = 1'b1;
      end
      // A half-written pair is held back so the VCO never sees a mixed setting.
      if (prog_en && r.hi_seen && r.lo_seen) begin
         next_r.n = {div_hi[`CGCR_N9_BIT], div_hi[`CGCR_N8_BIT], div_lo};
         next_r.m = div_hi[`CGCR_M_MSB:0];
         next_r.hi_seen = wr_hi;
         next_r.lo_seen = wr_lo;
      end
      if (!resetn) begin
         next_r.n = {RST_HI[`CGCR_N9_BIT], RST_HI[`CGCR_N8_BIT], RST_LO};
         next_r.m = RST_HI[`CGCR_M_MSB:0];
         next_r.hi_seen = 1'b0;
         next_r.lo_seen = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      r <= next_r;
   end

   assign fb_div = r.n;
   assign in_div = r.m;
endmodule : cgcr_pll_apply
`default_nettype wire

// ===== hw/cgcr_req_gate.sv
// Gating of the serial-link clock outputs by the clock request inputs.
`timescale 1ns/1ps
`default_nettype none
`include "cgcr_consts.svh"
module cgcr_req_gate (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] map_a,
   input wire logic [7:0] map_b,
   input wire logic req1_n,
   input wire logic req2_n,
   input wire logic req3_n,
   input wire logic req4_n,
   output logic [8:0] link_en
);
   cgcr_pkg::cgcr_gate_t r;
   cgcr_pkg::cgcr_gate_t next_r;

   // An output is stopped only when it is mapped and its request is released.
   always_comb begin
      next_r.en[8] = ~(map_a[`CGCR_MAP_HI] & req2_n);
      next_r.en[1] = ~(map_a[`CGCR_MAP_MID] & req2_n);
      next_r.en[6] = ~(map_a[`CGCR_MAP_LO1] & req1_n);
      next_r.en[0] = ~(map_a[`CGCR_MAP_LO0] & req1_n);
      next_r.en[7] = ~(map_b[`CGCR_MAP_HI] & req4_n);
      next_r.en[5] = ~(map_b[`CGCR_MAP_MID] & req4_n);
      next_r.en[3] = ~(map_b[`CGCR_MAP_B5] & req4_n);
      next_r.en[4] = ~(map_b[`CGCR_MAP_LO1] & req3_n);
      next_r.en[2] = ~(map_b[`CGCR_MAP_LO0] & req3_n);
      if (!resetn) begin
         next_r.en = `CGCR_LINK_EN_RST;
      end
   end

   always_ff @(posedge clk) begin
      r <= next_r;
   end

   assign link_en = r.en;
endmodule : cgcr_req_gate
`default_nettype wire

// ===== hw/cgcr_top.sv
// Configuration register bank with its two-wire serial slave.
`timescale 1ns/1ps
`default_nettype none
`include "cgcr_consts.svh"
module cgcr_top #(
   parameter logic [7:0] IDENT_CODE = `CGCR_IDENT_CODE // Value is arbitrary.
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   input wire logic clk_request_in_1_n,
   input wire logic clk_request_in_2_n,
   input wire logic clk_request_in_3_n,
   input wire logic clk_request_in_4_n,
   input wire logic shared_pair_strap,
   input wire logic shared_pair_source_strap,
   output logic [8:0] serial_link_clk_en,
   output logic [3:0] display_spread_sel,
   output logic shared_pair_link_sel,
   output logic ref0_enable,
   output logic display_spread_en,
   output logic pll_prog_enable,
   output logic [9:0] pll1_n,
   output logic [5:0] pll1_m,
   output logic [14:0] pll1_spread,
   output logic [9:0] pll2_n,
   output logic [5:0] pll2_m,
   output logic [14:0] pll2_spread,
   output logic sata_pll_select,
   output logic shared_pair_source_sel,
   output logic pcie_src_sata,
   output logic sata_spread_en,
   output logic [1:0] sata_spread_sel,
   output logic pci_src_sata
);
   cgcr_pkg::cgcr_top_t r;
   cgcr_pkg::cgcr_top_t next_r;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;

   assign scl_rise = scl_in & ~r.scl_q;
   assign scl_fall = ~scl_in & r.scl_q;
   assign start_seen = scl_in & r.scl_q & r.sda_q & ~sda_in;
   assign stop_seen = scl_in & r.scl_q & ~r.sda_q & sda_in;

   function automatic logic [7:0] wmask(
      input logic [7:0] old_v,
      input logic [7:0] new_v,
      input logic [7:0] mask
   );
      wmask = (old_v & ~mask) | (new_v & mask);
   endfunction : wmask

   // Indexes outside the bank read as zero.
   function automatic logic [7:0] rd_byte(
      input cgcr_pkg::cgcr_top_t s,
      input logic [7:0] idx
   );
      case (idx)
         `CGCR_IDX_IDENT: rd_byte = IDENT_CODE;
         `CGCR_IDX_MAPA: rd_byte = s.map_a;
         `CGCR_IDX_DISP: rd_byte = s.disp;
         `CGCR_IDX_CNT: rd_byte = s.cnt;
         `CGCR_IDX_P1H: rd_byte = s.p1h;
         `CGCR_IDX_P1L: rd_byte = s.p1l;
         `CGCR_IDX_S1L: rd_byte = s.s1l;
         `CGCR_IDX_S1H: rd_byte = s.s1h;
         `CGCR_IDX_MAPB: rd_byte = s.map_b;
         `CGCR_IDX_SATA: rd_byte = s.sata;
         `CGCR_IDX_P2H: rd_byte = s.p2h;
         `CGCR_IDX_P2L: rd_byte = s.p2l;
         `CGCR_IDX_S2L: rd_byte = s.s2l;
         `CGCR_IDX_S2H: rd_byte = s.s2h;
         default: rd_byte = 8'h00;
      endcase
   endfunction : rd_byte

   always_comb begin
      logic load;
      logic wr;
      logic [7:0] tx;
      load = 1'b0;
      wr = 1'b0;
      tx = 8'h00;
      next_r = r;
      next_r.scl_q = scl_in;
      next_r.sda_q = sda_in;
      next_r.wr_p1h = 1'b0;
      next_r.wr_p1l = 1'b0;
      next_r.wr_p2h = 1'b0;
      next_r.wr_p2l = 1'b0;
      // Straps are caught once, on the first edge after reset is released.
      if (!r.straps_done) begin
         next_r.disp[`CGCR_DISP_STRAP] = shared_pair_strap;
         next_r.sata[`CGCR_SATA_SRC] = shared_pair_source_strap;
         next_r.straps_done = 1'b1;
      end
      if ((r.st == cgcr_pkg::S_ADDR || r.st == cgcr_pkg::S_RECV) && scl_rise) begin
         next_r.sh = {r.sh[6:0], sda_in};
         next_r.bitcnt = r.bitcnt + 3'h1;
         next_r.byte_done = (r.bitcnt == `CGCR_LAST_BIT);
      end
      if (start_seen) begin
         next_r.st = cgcr_pkg::S_ADDR;
         next_r.bitcnt = 3'h0;
         next_r.byte_done = 1'b0;
         next_r.sda_oe_n = 1'b1;
      end else if (stop_seen) begin
         next_r.st = cgcr_pkg::S_IDLE;
         next_r.sda_oe_n = 1'b1;
      end else begin
         unique case (r.st)
            cgcr_pkg::S_IDLE: begin
               next_r.sda_oe_n = 1'b1;
            end
            cgcr_pkg::S_ADDR: begin
               if (scl_fall && r.byte_done) begin
                  next_r.byte_done = 1'b0;
                  next_r.phase = `CGCR_PH_INDEX;
                  if (r.sh == `CGCR_DEV_WR || r.sh == `CGCR_DEV_RD) begin
                     next_r.is_read = (r.sh == `CGCR_DEV_RD);
                     next_r.sda_oe_n = 1'b0;
                     next_r.st = cgcr_pkg::S_ACK;
                  end else begin
                     next_r.st = cgcr_pkg::S_IDLE;
                  end
               end
            end
            cgcr_pkg::S_RECV: begin
               if (scl_fall && r.byte_done) begin
                  next_r.byte_done = 1'b0;
                  next_r.sda_oe_n = 1'b0;
                  next_r.st = cgcr_pkg::S_ACK;
                  if (r.phase == `CGCR_PH_INDEX) begin
                     next_r.ptr = r.sh;
                     next_r.phase = `CGCR_PH_COUNT;
                  end else if (r.phase == `CGCR_PH_COUNT) begin
                     next_r.phase = `CGCR_PH_DATA;
                  end else begin
                     wr = 1'b1;
                  end
               end
            end
            cgcr_pkg::S_ACK: begin
               if (scl_fall) begin
                  next_r.sda_oe_n = 1'b1;
                  next_r.bitcnt = 3'h0;
                  if (r.is_read) begin
                     load = 1'b1;
                  end else begin
                     next_r.st = cgcr_pkg::S_RECV;
                  end
               end
            end
            cgcr_pkg::S_SEND: begin
               if (scl_fall) begin
                  if (r.bitcnt == `CGCR_LAST_BIT) begin
                     next_r.sda_oe_n = 1'b1;
                     next_r.st = cgcr_pkg::S_MACK;
                  end else begin
                     next_r.sh = {r.sh[6:0], 1'b0};
                     next_r.sda_oe_n = r.sh[6];
                     next_r.bitcnt = r.bitcnt + 3'h1;
                  end
               end
            end
            cgcr_pkg::S_MACK: begin
               if (scl_rise) begin
                  next_r.nack = sda_in;
               end else if (scl_fall) begin
                  if (r.nack) begin
                     next_r.st = cgcr_pkg::S_IDLE;
                  end else begin
                     next_r.bitcnt = 3'h0;
                     load = 1'b1;
                  end
               end
            end
            default: begin
               next_r.st = cgcr_pkg::S_IDLE;
               next_r.sda_oe_n = 1'b1;
            end
         endcase
      end
      // The count goes out first, then bytes from the written index onward.
      if (load) begin
         if (r.phase == `CGCR_PH_INDEX) begin
            tx = r.cnt & `CGCR_CNT_MASK;
            next_r.phase = `CGCR_PH_DATA;
         end else begin
            tx = rd_byte(r, r.ptr);
            next_r.ptr = r.ptr + 8'h01;
         end
         next_r.sh = tx;
         next_r.sda_oe_n = tx[7];
         next_r.st = cgcr_pkg::S_SEND;
      end
      if (wr) begin
         next_r.ptr = r.ptr + 8'h01;
         case (r.ptr)
            `CGCR_IDX_MAPA: next_r.map_a = r.sh;
            `CGCR_IDX_DISP: next_r.disp = wmask(r.disp, r.sh, `CGCR_WMASK_DISP);
            `CGCR_IDX_CNT: next_r.cnt = r.sh;
            `CGCR_IDX_P1H: begin
               next_r.p1h = r.sh;
               next_r.wr_p1h = 1'b1;
            end
            `CGCR_IDX_P1L: begin
               next_r.p1l = r.sh;
               next_r.wr_p1l = 1'b1;
            end
            `CGCR_IDX_S1L: next_r.s1l = r.sh;
            `CGCR_IDX_S1H: next_r.s1h = wmask(r.s1h, r.sh, `CGCR_WMASK_SSH1);
            `CGCR_IDX_MAPB: next_r.map_b = r.sh;
            `CGCR_IDX_SATA: next_r.sata = r.sh;
            `CGCR_IDX_P2H: begin
               next_r.p2h = r.sh;
               next_r.wr_p2h = 1'b1;
            end
            `CGCR_IDX_P2L: begin
               next_r.p2l = wmask(r.p2l, r.sh, `CGCR_WMASK_P2L);
               next_r.wr_p2l = 1'b1;
            end
            `CGCR_IDX_S2L: next_r.s2l = r.sh;
            `CGCR_IDX_S2H: next_r.s2h = r.sh;
            default: begin
            end
         endcase
      end
      if (!resetn) begin
         next_r = '0;
         next_r.st = cgcr_pkg::S_IDLE;
         next_r.scl_q = 1'b1;
         next_r.sda_q = 1'b1;
         next_r.sda_oe_n = 1'b1;
         next_r.map_a = `CGCR_RST_MAPA;
         next_r.map_b = `CGCR_RST_MAPB;
         next_r.disp = `CGCR_RST_DISP;
         next_r.cnt = `CGCR_RST_CNT;
         next_r.sata = `CGCR_RST_SATA;
         next_r.p1h = `CGCR_ROM_P1H;
         next_r.p1l = `CGCR_ROM_P1L;
         next_r.p2h = `CGCR_ROM_P2H;
         next_r.p2l = `CGCR_ROM_P2L;
         next_r.s1l = `CGCR_RST_SPREAD;
         next_r.s1h = `CGCR_RST_SPREAD;
         next_r.s2l = `CGCR_RST_SPREAD;
         next_r.s2h = `CGCR_RST_SPREAD;
      end
   end

   always_ff @(posedge clk) begin
      r <= next_r;
   end

   cgcr_req_gate u_gate (
      .clk(clk),
      .resetn(resetn),
      .map_a(r.map_a),
      .map_b(r.map_b),
      .req1_n(clk_request_in_1_n),
      .req2_n(clk_request_in_2_n),
      .req3_n(clk_request_in_3_n),
      .req4_n(clk_request_in_4_n),
      .link_en(serial_link_clk_en)
   );

   cgcr_pll_apply #(
      .RST_HI(`CGCR_ROM_P1H),
      .RST_LO(`CGCR_ROM_P1L)
   ) u_pll1 (
      .clk(clk),
      .resetn(resetn),
      .div_hi(r.p1h),
      .div_lo(r.p1l),
      .wr_hi(r.wr_p1h),
      .wr_lo(r.wr_p1l),
      .prog_en(r.disp[`CGCR_DISP_PROG]),
      .fb_div(pll1_n),
      .in_div(pll1_m)
   );

   // The second PLL shares the divider layout of the first.
   cgcr_pll_apply #(
      .RST_HI(`CGCR_ROM_P2H),
      .RST_LO(`CGCR_ROM_P2L)
   ) u_pll2 (
      .clk(clk),
      .resetn(resetn),
      .div_hi(r.p2h),
      .div_lo(r.p2l),
      .wr_hi(r.wr_p2h),
      .wr_lo(r.wr_p2l),
      .prog_en(r.disp[`CGCR_DISP_PROG]),
      .fb_div(pll2_n),
      .in_div(pll2_m)
   );

   assign sda_out = r.sda_out;
   assign sda_oe_n = r.sda_oe_n;
   assign display_spread_sel = r.disp[`CGCR_DISP_SS_MSB:`CGCR_DISP_SS_LSB];
   assign shared_pair_link_sel = r.disp[`CGCR_DISP_STRAP];
   assign ref0_enable = r.disp[`CGCR_DISP_REF0];
   assign display_spread_en = r.disp[`CGCR_DISP_SSEN];
   assign pll_prog_enable = r.disp[`CGCR_DISP_PROG];
   assign pll1_spread = {r.s1h[`CGCR_SS_HI_MSB:0], r.s1l};
   assign pll2_spread = {r.s2h[`CGCR_SS_HI_MSB:0], r.s2l};
   assign sata_pll_select = r.sata[`CGCR_SATA_SEL];
   assign shared_pair_source_sel = r.sata[`CGCR_SATA_SRC];
   assign pcie_src_sata = r.sata[`CGCR_SATA_PCIE];
   assign sata_spread_en = r.sata[`CGCR_SATA_SSEN];
   assign sata_spread_sel = r.sata[`CGCR_SATA_SS_MSB:`CGCR_SATA_SS_LSB];
   assign pci_src_sata = r.sata[`CGCR_SATA_PCI];
endmodule : cgcr_top
`default_nettype wire

// ===== tb/cgcr_top_sva.sv
// Concurrent checks on the ports of the configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module cgcr_top_chk (
   input wire logic clk,
   input wire logic resetn,
   input wire logic scl_in,
   input wire logic sda_oe_n,
   input wire logic clk_request_in_1_n,
   input wire logic clk_request_in_2_n,
   input wire logic clk_request_in_3_n,
   input wire logic clk_request_in_4_n,
   input wire logic shared_pair_strap,
   input wire logic shared_pair_source_strap,
   input wire logic [8:0] serial_link_clk_en,
   input wire logic [3:0] display_spread_sel,
   input wire logic shared_pair_link_sel,
   input wire logic ref0_enable,
   input wire logic display_spread_en,
   input wire logic pll_prog_enable,
   input wire logic shared_pair_source_sel,
   input wire logic [9:0] pll1_n,
   input wire logic [5:0] pll1_m,
   input wire logic [9:0] pll2_n,
   input wire logic [5:0] pll2_m
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   // A raised request keeps its outputs running whatever the mapping says.
   a_req1_runs: assert property (!clk_request_in_1_n |=> (serial_link_clk_en & 9'h041) == 9'h041)
      else $error("request one left an output stopped");
   a_req2_runs: assert property (!clk_request_in_2_n |=> (serial_link_clk_en & 9'h102) == 9'h102)
      else $error("request two left an output stopped");
   a_req3_runs: assert property (!clk_request_in_3_n |=> (serial_link_clk_en & 9'h014) == 9'h014)
      else $error("request three left an output stopped");
   a_req4_runs: assert property (!clk_request_in_4_n |=> (serial_link_clk_en & 9'h0a8) == 9'h0a8)
      else $error("request four left an output stopped");
   a_drive_scl_low: assert property ($fell(sda_oe_n) |-> !scl_in && !$past(scl_in))
      else $error("data line pulled while the serial clock was high");
   // The host holds each level at least one clock, so a driven bit lasts three.
   a_drive_held: assert property ($fell(sda_oe_n) |-> (!sda_oe_n) [*3])
      else $error("driven data bit released too early");
   a_div_gated: assert property (!pll_prog_enable && !$past(pll_prog_enable) && !$past(pll_prog_enable, 2)
      |-> $stable({pll1_n, pll1_m, pll2_n, pll2_m}))
      else $error("divider changed while programming disabled");
   a_strap_latch: assert property ($rose(resetn) |=> shared_pair_link_sel == $past(shared_pair_strap)
      && shared_pair_source_sel == $past(shared_pair_source_strap))
      else $error("strap not captured after reset");
   a_strap_kept: assert property (resetn && $past(resetn) && $past(resetn, 2) |-> $stable(shared_pair_link_sel))
      else $error("latched strap bit changed");
   a_reset_disp: assert property ($rose(resetn)
      |-> {display_spread_sel, ref0_enable, display_spread_en, pll_prog_enable} == 7'h3e)
      else $error("display control outputs not at reset value");
endmodule : cgcr_top_chk
bind cgcr_top cgcr_top_chk u_chk (.clk(clk), .resetn(resetn), .scl_in(scl_in), .sda_oe_n(sda_oe_n),
   .clk_request_in_1_n(clk_request_in_1_n), .clk_request_in_2_n(clk_request_in_2_n),
   .clk_request_in_3_n(clk_request_in_3_n), .clk_request_in_4_n(clk_request_in_4_n),
   .shared_pair_strap(shared_pair_strap), .shared_pair_source_strap(shared_pair_source_strap),
   .serial_link_clk_en(serial_link_clk_en), .display_spread_sel(display_spread_sel),
   .shared_pair_link_sel(shared_pair_link_sel), .ref0_enable(ref0_enable), .display_spread_en(display_spread_en),
   .pll_prog_enable(pll_prog_enable), .shared_pair_source_sel(shared_pair_source_sel),
   .pll1_n(pll1_n), .pll1_m(pll1_m), .pll2_n(pll2_n), .pll2_m(pll2_m));
`default_nettype wire

// ===== tb/cgcr_host.sv
// Two-wire bus host model that drives the bank's serial clock and data.
`timescale 1ns/1ps
`default_nettype none
`include "cgcr_consts.svh"
module cgcr_host (
   input wire logic clk,
   input wire logic sda_line,
   output logic scl_o,
   output logic sda_o
);
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   // Every level is held four clocks, four times the least the slave needs.
   task automatic hold();
      repeat (4) @(negedge clk);
   endtask : hold
   task automatic start_c();
      sda_o = 1'b1;
      hold();
      scl_o = 1'b1;
      hold();
      sda_o = 1'b0;
      hold();
      scl_o = 1'b0;
      hold();
   endtask : start_c
   task automatic stop_c();
      sda_o = 1'b0;
      hold();
      scl_o = 1'b1;
      hold();
      sda_o = 1'b1;
      hold();
   endtask : stop_c
   // Data moves only while the clock is low; the ninth slot is the acknowledge.
   task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic acked);
      logic [8:0] v;
      v = {tx, last};
      for (int i = 8; i >= 0; i--) begin
         sda_o = v[i];
         hold();
         scl_o = 1'b1;
         hold();
         rx = (i > 0) ? {rx[6:0], sda_line} : rx;
         acked = !sda_line;
         scl_o = 1'b0;
         hold();
      end
   endtask : xfer
   task automatic wr(input logic [7:0] idx, input logic [7:0] d[$], output logic ok);
      logic [7:0] r;
      logic a;
      start_c();
      xfer(`CGCR_DEV_WR, 1'b1, r, ok);
      xfer(idx, 1'b1, r, a);
      ok &= a;
      xfer(8'(d.size()), 1'b1, r, a);
      ok &= a;
      foreach (d[i]) begin
         xfer(d[i], 1'b1, r, a);
         ok &= a;
      end
      stop_c();
   endtask : wr
   task automatic rd(input logic [7:0] idx, input int n, output logic [7:0] q[$], output logic ok);
      logic [7:0] r;
      logic a;
      q = {};
      start_c();
      xfer(`CGCR_DEV_WR, 1'b1, r, ok);
      xfer(idx, 1'b1, r, a);
      ok &= a;
      start_c();
      xfer(`CGCR_DEV_RD, 1'b1, r, a);
      ok &= a;
      for (int i = 0; i <= n; i++) begin
         xfer(8'hff, i == n, r, a);
         q.push_back(r);
      end
      stop_c();
   endtask : rd
endmodule : cgcr_host
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench of the configuration register bank.
`timescale 1ns/1ps
`default_nettype none
`include "cgcr_consts.svh"
module tb;
   localparam logic [7:0] IDENT = 8'h5c; // Value is arbitrary.
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic strap = 1'b1;
   logic [3:0] req_n = 4'hf;
   logic scl, sda_h, sda_line, sda_out, sda_oe_n, lsel, ref0, dsen, prog, ssel, psel, pcie, sen, pci;
   logic [8:0] link_en;
   logic [3:0] dsel;
   logic [9:0] n1, n2;
   logic [5:0] m1, m2;
   logic [14:0] s1, s2;
   logic [1:0] sss;
   logic [7:0] q[$];
   logic ok;
   int n_errors = 0;
   int cmp_count = 0;
   int cycles = 0;
   always #10 clk = ~clk;
   // The line has a pull-up, so it is low only while some party pulls it.
   assign sda_line = sda_h & (sda_oe_n | sda_out);
   cgcr_top #(.IDENT_CODE(IDENT)) dut (
      .clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
      .clk_request_in_1_n(req_n[0]), .clk_request_in_2_n(req_n[1]), .clk_request_in_3_n(req_n[2]),
      .clk_request_in_4_n(req_n[3]), .shared_pair_strap(strap), .shared_pair_source_strap(~strap),
      .serial_link_clk_en(link_en), .display_spread_sel(dsel), .shared_pair_link_sel(lsel), .ref0_enable(ref0),
      .display_spread_en(dsen), .pll_prog_enable(prog), .pll1_n(n1), .pll1_m(m1), .pll1_spread(s1),
      .pll2_n(n2), .pll2_m(m2), .pll2_spread(s2), .sata_pll_select(ssel), .shared_pair_source_sel(psel),
      .pcie_src_sata(pcie), .sata_spread_en(sen), .sata_spread_sel(sss), .pci_src_sata(pci));
   cgcr_host host (.clk(clk), .sda_line(sda_line), .scl_o(scl), .sda_o(sda_h));
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : complete_run
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         chk("run within cycle limit", 32'h0, 32'h1);
         complete_run();
      end
   end
   task automatic do_reset();
      @(negedge clk);
      resetn = 1'b0;
      repeat (12) @(negedge clk);
      resetn = 1'b1;
      repeat (4) @(negedge clk);
   endtask : do_reset
   task automatic t_reset_read();
      logic [7:0] e[14] = '{IDENT, 8'h3c, 8'h76 | {4'h0, strap, 3'h0}, 8'h15, `CGCR_ROM_P1H, `CGCR_ROM_P1L, 8'h00,
         8'h00, 8'h00, 8'h9d | {1'b0, ~strap, 6'h0}, `CGCR_ROM_P2H, `CGCR_ROM_P2L, 8'h00, 8'h00};
      host.rd(`CGCR_IDX_IDENT, 14, q, ok);
      chk("read acknowledged", ok, 1'b1);
      chk("count byte", q[0], 8'h15);
      foreach (e[i]) chk($sformatf("reset byte %0h", i + 7), q[i + 1], e[i]);
      chk("links running", link_en, 9'h1ff);
      chk("data output level", sda_out, 1'b0);
      $display("reset read test done");
   endtask : t_reset_read
   task automatic t_write_back();
      logic [7:0] d[$] = {8'hff, 8'hc3, 8'h96, 8'hff, 8'h5a, 8'ha5, 8'h34, 8'hff, 8'he3, 8'h42, 8'hc7, 8'hff,
         8'h12, 8'hff};
      logic [7:0] e[$] = {IDENT, 8'hc3, 8'h9e, 8'hff, 8'h5a, 8'ha5, 8'h34, 8'h7f, 8'he3, 8'h42, 8'hc7,
         `CGCR_ROM_P2L | 8'h7f, 8'h12, 8'hff};
      host.wr(`CGCR_IDX_IDENT, d, ok);
      chk("write acknowledged", ok, 1'b1);
      host.rd(`CGCR_IDX_IDENT, 14, q, ok);
      chk("new count byte", q[0], 8'h1f);
      foreach (e[i]) chk($sformatf("byte %0h", i + 7), q[i + 1], e[i]);
      chk("display outputs", {dsel, lsel, ref0, dsen, prog}, 8'h9e);
      chk("sata outputs", {ssel, psel, pcie, sen, sss, pci}, 7'h21);
      chk("first spread", s1, 15'h7f34);
      chk("second spread", s2, 15'h7f12);
      chk("dividers held", {n1, m1, n2, m2}, 32'h0);
      $display("write and read back test done");
   endtask : t_write_back
   task automatic t_req_gate();
      logic [8:0] m[4] = '{9'h041, 9'h102, 9'h014, 9'h0a8};
      chk("all stopped", link_en, 9'h000);
      for (int i = 0; i < 4; i++) begin
         req_n = ~(4'h1 << i);
         repeat (2) @(negedge clk);
         chk($sformatf("links for request %0d", i + 1), link_en, m[i]);
      end
      req_n = 4'hf;
      $display("request gating test done");
   endtask : t_req_gate
   task automatic t_pll_apply();
      host.wr(`CGCR_IDX_DISP, {8'h97}, ok);
      repeat (4) @(negedge clk);
      chk("first pll applied", {n1, m1}, {10'h2a5, 6'h1a});
      chk("second pll applied", {n2, m2}, {10'h37f, 6'h07});
      host.wr(`CGCR_IDX_P1H, {8'h41}, ok);
      repeat (4) @(negedge clk);
      chk("half written pair", {n1, m1}, {10'h2a5, 6'h1a});
      host.wr(`CGCR_IDX_P1L, {8'h10}, ok);
      repeat (4) @(negedge clk);
      chk("whole pair", {n1, m1}, {10'h210, 6'h01});
      $display("divider apply test done");
   endtask : t_pll_apply
   task automatic t_refused();
      logic [7:0] r;
      logic a;
      host.start_c();
      host.xfer(8'ha4, 1'b1, r, a);
      host.stop_c();
      chk("foreign address acknowledged", a, 1'b0);
      host.rd(8'h15, 1, q, ok);
      chk("outside byte", q[1], 8'h00);
      $display("refusal test done");
   endtask : t_refused
   initial begin
      do_reset();
      t_reset_read();
      t_write_back();
      t_req_gate();
      t_pll_apply();
      t_refused();
      strap = 1'b0;
      do_reset();
      t_reset_read();
      complete_run();
   end
endmodule : tb
`default_nettype wire
